// ==== hw/adcc_defines.svh ====
// Purpose: Constants for the converter control block
// Assumes: Classic Wishbone, 32-bit data, byte addresses
// Notes:   Offsets, field positions, reset values and counts
`ifndef ADCC_DEFINES_SVH
`define ADCC_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ADCC_OFS_CTRL_A     8'h00
`define ADCC_OFS_CTRL_B     8'h04
`define ADCC_OFS_RES_LOW    8'h08
`define ADCC_OFS_RES_HIGH   8'h0C
`define ADCC_OFS_CAL_LOW    8'h10
`define ADCC_OFS_CAL_HIGH   8'h14
`define ADCC_OFS_OPT_MAP    8'h18
`define ADCC_OFS_IRQ_STAT   8'h1C
`define ADCC_OFS_IRQ_MASK   8'h20

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ADCC_A_CHAN_LSB     0
`define ADCC_A_START        4
`define ADCC_A_ENABLE       5
`define ADCC_A_BUSY         7
`define ADCC_B_INSEL_LSB    0
`define ADCC_B_REF_LSB      3
`define ADCC_B_TEMP_SENSOR_ENABLE         5
`define ADCC_B_CKDIV_LSB    6
`define ADCC_B_REF_BITS     4:3
`define ADCC_B_CKDIV_BITS   8:6
`define ADCC_IRQ_EOC        0

// ----------------------------------------------------------------
// Reset values, codes and counts
// ----------------------------------------------------------------
`define ADCC_INSEL_FORBID   3'h7
`define ADCC_INSEL_TEMP     3'h2
`define ADCC_CYC_EXT        6'h10
`define ADCC_CYC_TEMP       6'h3A
`define ADCC_TBL_ADC2_HI    14'h3FF5
`define ADCC_TBL_ADC2_LO    14'h3FF6
`define ADCC_TBL_T2         14'h3FF7
`define ADCC_RST_CTRL_A     8'h00
`define ADCC_RST_CTRL_B     9'h000

`endif

// ==== hw/adcc_pkg.sv ====
// Purpose: Types shared by the converter control files
// Assumes: Constants come from adcc_defines.svh
// Notes:   One-hot sequencer states
package adcc_pkg;
    typedef enum logic [3:0] {
        ADCC_IDLE   = 4'b0001,
        ADCC_ARMED  = 4'b0010,
        ADCC_SAMPLE = 4'b0100,
        ADCC_DONE   = 4'b1000
    } adcc_state_t;
endpackage

// ==== hw/adcc_seq.sv ====
// Purpose: Conversion sequencer paced by converter clock ticks
// Assumes: tick_i is a one-cycle strobe per converter clock
// Notes:   The analog core supplies the code on sample_i
`timescale 1ns/10ps
`include "adcc_defines.svh"
module adcc_seq #(
    parameter int RES_W = 12
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             enable_i,
    input  wire logic             start_i,
    input  wire logic             temp_i,
    input  wire logic             tick_i,
    input  wire logic [RES_W-1:0] sample_i,
    output logic                  busy_o,
    output logic                  done_o,
    output logic [RES_W-1:0]      result_o
);
    typedef struct packed {
        adcc_pkg::adcc_state_t st;
        logic [5:0]            cnt;
        logic                  start_d;
        logic                  done;
        logic [RES_W-1:0]      res;
    } adcc_seq_t;
    adcc_seq_t cur;
    adcc_seq_t next_cur;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // Start high holds the converter in reset; its fall launches a run
    always_comb begin
        next_cur = cur;
        next_cur.start_d = start_i;
        next_cur.done = 1'b0;
        unique case (cur.st)
            adcc_pkg::ADCC_IDLE: begin
                if (start_i) next_cur.st = adcc_pkg::ADCC_ARMED;
            end
            adcc_pkg::ADCC_ARMED: begin
                if (!start_i) begin
                    next_cur.st  = adcc_pkg::ADCC_SAMPLE;
                    next_cur.cnt = temp_i ? `ADCC_CYC_TEMP : `ADCC_CYC_EXT;
                end
            end
            adcc_pkg::ADCC_SAMPLE: begin
                if (start_i) begin
                    next_cur.st = adcc_pkg::ADCC_ARMED;
                end else if (tick_i) begin
                    next_cur.cnt = cur.cnt - 6'h01;
                    if (cur.cnt == 6'h01) next_cur.st = adcc_pkg::ADCC_DONE;
                end
            end
            adcc_pkg::ADCC_DONE: begin
                // Result, busy and done all change on this one edge
                next_cur.res  = sample_i;
                next_cur.done = 1'b1;
                next_cur.st   = adcc_pkg::ADCC_IDLE;
            end
            default: next_cur.st = adcc_pkg::ADCC_IDLE;
        endcase
        if (!enable_i) begin
            next_cur.st = adcc_pkg::ADCC_IDLE;
            next_cur.cnt = 6'h00;
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cur <= '{st: adcc_pkg::ADCC_IDLE, default: '0};
        end else begin
            cur <= next_cur;
        end
    end

    assign busy_o   = cur.st != adcc_pkg::ADCC_IDLE;
    assign done_o   = cur.done;
    assign result_o = cur.res;

    a_no_run_off: assert property (@(posedge clk_i) disable iff (rst_i)
        !enable_i |=> !busy_o) else $error("busy while disabled");
    a_done_clears: assert property (@(posedge clk_i) disable iff (rst_i)
        done_o |-> !busy_o && $past(busy_o)) else $error("done without busy end");
endmodule

// ==== hw/adcc_tbl.sv ====
// Purpose: Mapped calibration lookup in the last program page
// Assumes: Factory values arrive as constant inputs
// Notes:   Reads zero while the mapping is off
`timescale 1ns/10ps
`include "adcc_defines.svh"
module adcc_tbl (
    input  wire logic        map_en_i,
    input  wire logic [13:0] addr_i,
    input  wire logic [11:0] adc2_i,
    input  wire logic [7:0]  t2_i,
    output logic             hit_o,
    output logic [7:0]       data_o
);
    // Combinational decode of the three mapped words
    always_comb begin
        hit_o  = map_en_i;
        data_o = 8'h00;
        if (map_en_i) begin
            unique case (addr_i)
                `ADCC_TBL_ADC2_HI: data_o = adc2_i[11:4];
                `ADCC_TBL_ADC2_LO: data_o = {4'h0, adc2_i[3:0]};
                `ADCC_TBL_T2:      data_o = t2_i;
                default:           hit_o  = 1'b0;
            endcase
        end
    end
endmodule

// ==== hw/adcc_top.sv ====
// Purpose: Wishbone register file around the converter sequencer
// Assumes: 125 MHz system clock, synchronous active-high reset
// Notes:   Ack follows one cycle after the strobe, one cycle wide
`timescale 1ns/10ps
`include "adcc_defines.svh"
module adcc_top #(
    parameter int RES_W = 12
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic [RES_W-1:0] sample_i,
    input  wire logic [11:0] cal_adc1_i,
    input  wire logic [11:0] cal_adc2_i,
    input  wire logic [7:0]  cal_t2_i,
    input  wire logic [13:0] tbl_addr_i,
    output logic [7:0]       tbl_data_o,
    output logic             tbl_hit_o,
    output logic             power_on_o,
    output logic [1:0]       ref_select_o,
    output logic [3:0]       external_channel_select_o,
    output logic [2:0]       internal_input_select_o,
    output logic             temp_sensor_enable_o,
    output logic             irq_o
);
    typedef struct packed {
        logic [7:0]  conv_control_a;
        logic [8:0]  conv_control_b;
        logic        option_map_control;
        logic        irq_stat;
        logic        irq_mask;
        logic [RES_W-1:0] res;
        logic [2:0]  div;
        logic        tick;
        logic        ack;
        logic [31:0] dat;
        logic        irq;
        logic [7:0]  tbl;
        logic        hit;
    } adcc_top_t;
    adcc_top_t cur;
    adcc_top_t next_cur;

    logic             busy;
    logic             done;
    logic [RES_W-1:0] result;
    logic             tbl_hit;
    logic [7:0]       tbl_data;
    logic             req;

    assign req = wb_cyc_i & wb_stb_i & ~cur.ack;

    // ------------------------------------------------------------
    // Sub-blocks
    // ------------------------------------------------------------
    adcc_seq #(.RES_W(RES_W)) u_seq (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .enable_i (cur.conv_control_a[`ADCC_A_ENABLE]),
        .start_i  (cur.conv_control_a[`ADCC_A_START]),
        .temp_i   (cur.conv_control_b[2:0] == `ADCC_INSEL_TEMP),
        .tick_i   (cur.tick),
        .sample_i (sample_i),
        .busy_o   (busy),
        .done_o   (done),
        .result_o (result)
    );

    adcc_tbl u_tbl (
        .map_en_i (cur.option_map_control),
        .addr_i   (tbl_addr_i),
        .adc2_i   (cal_adc2_i),
        .t2_i     (cal_t2_i),
        .hit_o    (tbl_hit),
        .data_o   (tbl_data)
    );

    // Read mux, byte-wide registers in the low lane, control B bit 8 in lane 1
    function automatic logic [31:0] rd_word(input logic [7:0] a, input adcc_top_t s,
                                            input logic bz);
        logic [31:0] w;
        w = 32'h0000_0000;
        unique case (a)
            `ADCC_OFS_CTRL_A:   w = {24'h00_0000, bz, s.conv_control_a[6:0]};
            `ADCC_OFS_CTRL_B:   w = {23'h00_0000, s.conv_control_b};
            `ADCC_OFS_RES_LOW:  w = {24'h00_0000, s.res[3:0], 4'h0};
            `ADCC_OFS_RES_HIGH: w = {24'h00_0000, s.res[11:4]};
            `ADCC_OFS_CAL_LOW:  w = {24'h00_0000, cal_adc1_i[3:0], 4'h0};
            `ADCC_OFS_CAL_HIGH: w = {24'h00_0000, cal_adc1_i[11:4]};
            `ADCC_OFS_OPT_MAP:  w = {31'h0000_0000, s.option_map_control};
            `ADCC_OFS_IRQ_STAT: w = {31'h0000_0000, s.irq_stat};
            `ADCC_OFS_IRQ_MASK: w = {31'h0000_0000, s.irq_mask};
            default:            w = 32'h0000_0000;
        endcase
        return w;
    endfunction

    // ------------------------------------------------------------
    // Register file and clock divider
    // ------------------------------------------------------------
    // Writes only take lane 0 (and lane 1 for the wider control B)
    always_comb begin
        next_cur = cur;
        next_cur.ack = req;
        // Busy reads high through the done cycle, so it drops with status and result
        next_cur.dat = req ? rd_word(wb_adr_i, cur, busy | done) : 32'h0000_0000;
        // Converter clock: system clock divided by 2^div, by 8 for any div of 3 or more
        next_cur.div = cur.div + 3'h1;
        next_cur.tick = (cur.div & ((3'h1 << cur.conv_control_b[8:6]) - 3'h1)) == 3'h0;
        if (done) next_cur.res = result;
        if (req && wb_we_i && wb_sel_i[0]) begin
            unique case (wb_adr_i)
                `ADCC_OFS_CTRL_A: next_cur.conv_control_a = {1'b0, wb_dat_i[6:0]};
                `ADCC_OFS_CTRL_B: begin
                    next_cur.conv_control_b[7:3] = wb_dat_i[7:3];
                    if (wb_sel_i[1]) next_cur.conv_control_b[8] = wb_dat_i[8];
                    if (wb_dat_i[2:0] != `ADCC_INSEL_FORBID)
                        next_cur.conv_control_b[2:0] = wb_dat_i[2:0];
                end
                `ADCC_OFS_OPT_MAP:  next_cur.option_map_control = wb_dat_i[0];
                `ADCC_OFS_IRQ_STAT: next_cur.irq_stat = cur.irq_stat & ~wb_dat_i[0];
                `ADCC_OFS_IRQ_MASK: next_cur.irq_mask = wb_dat_i[0];
                default: ;
            endcase
        end
        // Set beats clear so a completion is never lost
        if (done) next_cur.irq_stat = 1'b1;
        next_cur.irq = next_cur.irq_stat & next_cur.irq_mask;
        next_cur.tbl = tbl_data;
        next_cur.hit = tbl_hit;
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign wb_dat_o     = cur.dat;
    assign wb_ack_o     = cur.ack;
    assign irq_o        = cur.irq;
    assign tbl_data_o   = cur.tbl;
    assign tbl_hit_o    = cur.hit;
    assign power_on_o   = cur.conv_control_a[`ADCC_A_ENABLE];
    assign ref_select_o = cur.conv_control_b[`ADCC_B_REF_BITS];
    assign external_channel_select_o = cur.conv_control_a[3:0];
    assign internal_input_select_o   = cur.conv_control_b[2:0];
    assign temp_sensor_enable_o      = cur.conv_control_b[`ADCC_B_TEMP_SENSOR_ENABLE];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Control writes decoded once; a write lands on the edge that takes it
    logic wr_a;
    logic wr_b;
    assign wr_a = req && wb_we_i && wb_sel_i[0] && (wb_adr_i == `ADCC_OFS_CTRL_A);
    assign wr_b = req && wb_we_i && wb_sel_i[0] && (wb_adr_i == `ADCC_OFS_CTRL_B);

    // Select field never holds the forbidden code, and a write of it is dropped
    a_insel_legal: assert property (@(posedge clk_i) disable iff (rst_i)
        internal_input_select_o != 3'h7) else $error("forbidden input select");
    a_insel_keep: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_b && (wb_dat_i[2:0] == `ADCC_INSEL_FORBID) |=> $stable(internal_input_select_o))
        else $error("forbidden select was stored");

    // Completion: status, result and busy all move on one edge
    a_irq_on_done: assert property (@(posedge clk_i) disable iff (rst_i)
        done |=> cur.irq_stat) else $error("done did not set status");
    a_flags_together: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(cur.irq_stat) |-> $fell(busy | done)) else $error("busy and status apart");
    a_res_on_done: assert property (@(posedge clk_i) disable iff (rst_i)
        done |=> cur.res == $past(result)) else $error("result not loaded");
    a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
        irq_o == (cur.irq_stat && cur.irq_mask)) else $error("irq level wrong");

    // Power and reference follow their register bits
    a_power_off: assert property (@(posedge clk_i) disable iff (rst_i)
        !power_on_o |=> !busy) else $error("busy while powered down");
    a_power_write: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_a |=> power_on_o == $past(wb_dat_i[`ADCC_A_ENABLE])) else $error("enable write lost");
    a_ref_write: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_b |=> ref_select_o == $past(wb_dat_i[`ADCC_B_REF_BITS])) else $error("ref write lost");

    // Table reads: gated by the mapping bit, one cycle behind the address
    a_tbl_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(cur.option_map_control) |-> tbl_data_o == 8'h00) else $error("map leak");
    a_tbl_high: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(cur.option_map_control) && ($past(tbl_addr_i) == `ADCC_TBL_ADC2_HI) |->
        tbl_hit_o && (tbl_data_o == cal_adc2_i[11:4])) else $error("code high byte wrong");
    a_tbl_temp: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(cur.option_map_control) && ($past(tbl_addr_i) == `ADCC_TBL_T2) |->
        tbl_hit_o && (tbl_data_o == cal_t2_i)) else $error("temperature code wrong");

    // Bus answer and run bookkeeping; a disable is seen one edge late by design
    a_ack_one: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o) else $error("ack wider than one");
    a_start_run: assert property (@(posedge clk_i) disable iff (rst_i)
        busy && !done |-> $past(power_on_o)) else $error("run without power");

    c_conv: cover property (@(posedge clk_i) done);
    c_irq: cover property (@(posedge clk_i) irq_o);
    c_tbl: cover property (@(posedge clk_i) tbl_hit_o);
    c_abort: cover property (@(posedge clk_i) !power_on_o && busy);
    c_temp: cover property (@(posedge clk_i) done && (internal_input_select_o == `ADCC_INSEL_TEMP));
endmodule

// ==== testbench/test_adc_conversion_control.sv ====
// Purpose: Self-checking bench for the converter control block
// Assumes: Wishbone ack one cycle after the strobe; converter tick every cycle, every second cycle in the third timed conversion
// Notes:   Conversion length is judged from the interrupt line, polled each cycle
`timescale 1ns/10ps
module test_adc_conversion_control;
    logic        clk_i      = 1'b0;
    logic        rst_i      = 1'b1;
    logic        wb_cyc_i   = 1'b0;
    logic        wb_stb_i   = 1'b0;
    logic        wb_we_i    = 1'b0;
    logic [7:0]  wb_adr_i   = 8'h00;
    logic [3:0]  wb_sel_i   = 4'h0;
    logic [31:0] wb_dat_i   = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic [11:0] sample_i   = 12'h000;
    logic [11:0] cal_adc1_i = 12'hA5C;
    logic [11:0] cal_adc2_i = 12'h3B7;
    logic [7:0]  cal_t2_i   = 8'h9D;
    logic [13:0] tbl_addr_i = 14'h0000;
    logic [7:0]  tbl_data_o;
    logic        tbl_hit_o;
    logic        power_on_o;
    logic [1:0]  ref_select_o;
    logic [3:0]  ext_sel;
    logic [2:0]  int_sel;
    logic        temp_sensor_enable;
    logic        irq_o;
    int          failures   = 0;
    int          n_compared = 0;
    logic [31:0] rd;

    // ----------------------------------------------------------------
    // Clock, device and watchdog
    // ----------------------------------------------------------------
    always #4 clk_i = ~clk_i;

    adcc_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sample_i(sample_i),
        .cal_adc1_i(cal_adc1_i), .cal_adc2_i(cal_adc2_i), .cal_t2_i(cal_t2_i),
        .tbl_addr_i(tbl_addr_i), .tbl_data_o(tbl_data_o), .tbl_hit_o(tbl_hit_o),
        .power_on_o(power_on_o), .ref_select_o(ref_select_o),
        .external_channel_select_o(ext_sel), .internal_input_select_o(int_sel),
        .temp_sensor_enable_o(temp_sensor_enable), .irq_o(irq_o));

    // Generous span: the whole run needs well under two thousand cycles
    initial begin
        #160000;
        failures = failures + 1;
        conclude();
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared = n_compared + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Classic cycle: hold everything until ack is sampled, then one idle cycle
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hF;
        wb_dat_i <= dat;
        do begin
            @(posedge clk_i);
            n = n + 1;
        end while (wb_ack_o !== 1'b1 && n < 50);
        rd = wb_dat_o;
        if (n >= 50) check(32'h0000_0000, 32'h0000_0001);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        @(posedge clk_i);
    endtask

    // Start pulse low-high-low, then time completion on the interrupt line
    task automatic convert(input logic [11:0] code, input int lo, input int hi);
        int n;
        n = 0;
        sample_i <= code;
        wb(1'b1, 8'h00, 32'h0000_0020);
        wb(1'b1, 8'h00, 32'h0000_0030);
        wb(1'b0, 8'h00, 32'h0000_0000);
        check(rd[7], 1'b1);
        wb(1'b1, 8'h00, 32'h0000_0020);
        wb(1'b0, 8'h00, 32'h0000_0000);
        check(rd[7], 1'b1);
        while (irq_o !== 1'b1 && n < 200) begin
            @(posedge clk_i);
            n = n + 1;
        end
        check(n + 6 >= lo && n + 6 <= hi, 1'b1);
        wb(1'b0, 8'h00, 32'h0000_0000);
        check(rd[7], 1'b0);
        wb(1'b0, 8'h08, 32'h0000_0000);
        check(rd, {24'h0, code[3:0], 4'h0});
        wb(1'b0, 8'h0C, 32'h0000_0000);
        check(rd, {24'h0, code[11:4]});
        wb(1'b0, 8'h1C, 32'h0000_0000);
        check(rd[0], 1'b1);
        wb(1'b1, 8'h1C, 32'h0000_0001);
        check(irq_o, 1'b0);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset_and_select();
        wb(1'b0, 8'h00, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        check(power_on_o, 1'b0);
        wb(1'b0, 8'h24, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        wb(1'b1, 8'h04, 32'h0000_0032);
        check({temp_sensor_enable, ref_select_o, int_sel}, 6'h32);
        wb(1'b1, 8'h04, 32'h0000_0027);
        check(int_sel, 3'h2);
        check(ref_select_o, 2'h0);
        wb(1'b1, 8'h04, 32'h0000_0000);
        wb(1'b1, 8'h00, 32'h0000_0023);
        check({power_on_o, ext_sel}, 5'h13);
    endtask

    task automatic t_interrupt_mask();
        wb(1'b1, 8'h20, 32'h0000_0000);
        sample_i <= 12'h111;
        wb(1'b1, 8'h00, 32'h0000_0030);
        wb(1'b1, 8'h00, 32'h0000_0020);
        repeat (40) @(posedge clk_i);
        check(irq_o, 1'b0);
        wb(1'b0, 8'h1C, 32'h0000_0000);
        check(rd[0], 1'b1);
        wb(1'b1, 8'h20, 32'h0000_0001);
        check(irq_o, 1'b1);
        wb(1'b1, 8'h1C, 32'h0000_0001);
    endtask

    task automatic t_abort();
        wb(1'b1, 8'h00, 32'h0000_0030);
        wb(1'b1, 8'h00, 32'h0000_0020);
        wb(1'b1, 8'h00, 32'h0000_0000);
        check(power_on_o, 1'b0);
        wb(1'b0, 8'h00, 32'h0000_0000);
        check(rd[7], 1'b0);
        repeat (30) @(posedge clk_i);
        check(irq_o, 1'b0);
    endtask

    task automatic t_calibration();
        wb(1'b0, 8'h10, 32'h0000_0000);
        check(rd, {24'h0, cal_adc1_i[3:0], 4'h0});
        wb(1'b0, 8'h14, 32'h0000_0000);
        check(rd, {24'h0, cal_adc1_i[11:4]});
        tbl_addr_i <= 14'h3FF5;
        @(posedge clk_i);
        @(posedge clk_i);
        check({tbl_hit_o, tbl_data_o}, 9'h000);
        wb(1'b1, 8'h18, 32'h0000_0001);
        check({tbl_hit_o, tbl_data_o}, {1'b1, cal_adc2_i[11:4]});
        tbl_addr_i <= 14'h3FF6;
        @(posedge clk_i);
        @(posedge clk_i);
        check({tbl_hit_o, tbl_data_o}, {1'b1, 4'h0, cal_adc2_i[3:0]});
        tbl_addr_i <= 14'h3FF7;
        @(posedge clk_i);
        @(posedge clk_i);
        check({tbl_hit_o, tbl_data_o}, {1'b1, cal_t2_i});
        tbl_addr_i <= 14'h3FF4;
        @(posedge clk_i);
        @(posedge clk_i);
        check(tbl_hit_o, 1'b0);
    endtask

    // ----------------------------------------------------------------
    // Main sequence and verdict
    // ----------------------------------------------------------------
    task automatic conclude();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset_and_select();
        wb(1'b1, 8'h20, 32'h0000_0001);
        convert(12'hC3A, 16, 22);
        wb(1'b1, 8'h04, 32'h0000_0022);
        convert(12'h5E1, 58, 64);
        wb(1'b1, 8'h04, 32'h0000_0040);
        convert(12'h2D4, 32, 40);
        wb(1'b1, 8'h04, 32'h0000_0000);
        t_interrupt_mask();
        t_abort();
        t_calibration();
        conclude();
    end
endmodule
